// file: design/eoac_alarm_ctrl.sv
// engine-off timer alarm control: enables, alarm values, counters and actions
// Notes on behaviour
// RULE_01 - count-down running status reads at bit 7, read only
// RULE_02 - elapsed timer running status reads at bit 3, read only
// RULE_03 - count-down alarm on zero only while enable bit 4 set
// RULE_04 - overflow alarm only while enable bit 2 set
// RULE_05 - power-down alarm on match only while enable bit 1 set
// RULE_06 - wake-up alarm on match only while enable bit 0 set
// RULE_07 - record clear refused while its enable is set and condition persists
// RULE_08 - count-down action: none, exit deep stop, exit standby, exit timer-only
// RULE_09 - exit actions happen only when in the named low-power state
// RULE_10 - power-down action: none, enter deep stop, standby, timer-only
// RULE_11 - power-down action only taken from the active state
// RULE_12 - wake-up action field uses count-down encoding
// RULE_13 - after an action, pin control stays overridden until field is zero
// RULE_14 - leaving timer-only restarts converter and regulators one to four
// RULE_15 - power-down value loads whole when high byte written
// RULE_16 - host writes power-down low byte then high byte
// RULE_17 - wake-up 24-bit value loads when top byte written
// RULE_18 - wake-up low and middle writes buffered until top byte
// RULE_19 - host loads wake-up bytes in ascending order
// RULE_20 - elapsed timer saturates at maximum and flags overflow fault
// RULE_21 - count-down stops at zero and flags zero fault
// RULE_22 - matches compare live count with active values per increment
`timescale 1ns/1ps
`include "eoac_regs.svh"

module eoac_alarm_ctrl #(
  parameter int ET_WIDTH = 24,
  parameter int CD_WIDTH = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // serial register port, already decoded to byte accesses
  input wire eoac_pkg::eoac_reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  // timer controls from the neighbouring control register
  input wire logic et_enable,
  input wire logic et_stop,
  input wire logic et_tick,
  input wire logic et_reset,
  input wire logic cd_enable,
  input wire logic cd_stop,
  input wire logic cd_tick,
  input wire logic cd_set,
  // alarm record clear requests, one bit per alarm {cd, ovf, pd, wu}
  input wire logic [3:0] record_clear,
  // present power state from the power-state machine
  input wire eoac_pkg::eoac_pstate_type power_state,
  // results
  output logic [3:0] alarm_record,
  output logic pin_control_override,
  output eoac_pkg::eoac_trans_type trans_req,
  output logic [ET_WIDTH-1:0] et_count,
  output logic [CD_WIDTH-1:0] cd_count
);

  // byte address compare, shared by every write decode
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] b);
    addr_hit = (a == b);
  endfunction

  // registers
  logic [7:0] enable_q;
  logic [5:0] action_q;
  logic [7:0] pd_low_buf_q;
  logic [15:0] pd_value_q;
  logic [7:0] wu_low_buf_q;
  logic [7:0] wu_mid_buf_q;
  logic [23:0] wu_value_q;
  logic [3:0] record_q;
  logic [3:0] record_d;
  logic override_q;
  eoac_pkg::eoac_trans_type trans_q;
  eoac_pkg::eoac_trans_type trans_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [ET_WIDTH-1:0] et_q;
  logic [CD_WIDTH-1:0] cd_q;
  logic et_running;
  logic countdown_active_flag;

  // register write decode
  wire wr_enable = reg_req.wr && addr_hit(reg_req.addr, `EOAC_ADDR_ENABLE);
  wire wr_action = reg_req.wr && addr_hit(reg_req.addr, `EOAC_ADDR_ACTION);
  wire wr_pd_low = reg_req.wr && addr_hit(reg_req.addr, `EOAC_ADDR_PD_LOW);
  wire wr_pd_high = reg_req.wr && addr_hit(reg_req.addr, `EOAC_ADDR_PD_HIGH);
  wire wr_wu_low = reg_req.wr && addr_hit(reg_req.addr, `EOAC_ADDR_WU_LOW);
  wire wr_wu_mid = reg_req.wr && addr_hit(reg_req.addr, `EOAC_ADDR_WU_MID);
  wire wr_wu_high = reg_req.wr && addr_hit(reg_req.addr, `EOAC_ADDR_WU_HIGH);

  // enable bits and action fields
  wire countdown_alarm_enable = enable_q[`EOAC_BIT_CD_EN];
  wire overflow_alarm_enable = enable_q[`EOAC_BIT_OVF_EN];
  wire powerdown_alarm_enable = enable_q[`EOAC_BIT_PD_EN];
  wire wakeup_alarm_enable = enable_q[`EOAC_BIT_WU_EN];
  wire [1:0] cd_action = action_q[5:4];
  wire [1:0] pd_action = action_q[3:2];
  wire [1:0] wu_action = action_q[1:0];

  // counter state: running means enabled, not paused and not at its end stop
  wire et_at_max = (et_q == {ET_WIDTH{1'b1}});
  wire cd_at_zero = (cd_q == '0);
  assign et_running = et_enable && !et_stop && !et_at_max;
  assign countdown_active_flag = cd_enable && !cd_stop && !cd_at_zero;
  wire et_inc = et_running && et_tick && !et_reset;

  // elapsed timer: held clear when disabled, saturates at the top
  // RULE_20 elapsed timer saturation
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      et_q <= '0;
    end else if (!et_enable || et_reset) begin
      et_q <= '0;
    end else if (et_inc) begin
      et_q <= et_q + 1'b1;
    end
  end

  // count-down timer: held at its set value when disabled, stops at zero
  // RULE_21 count-down end stop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cd_q <= CD_WIDTH'(`EOAC_CD_SET_VALUE);
    end else if (!cd_enable || cd_set) begin
      cd_q <= CD_WIDTH'(`EOAC_CD_SET_VALUE);
    end else if (countdown_active_flag && cd_tick) begin
      cd_q <= cd_q - 1'b1;
    end
  end

  // compare matches are checked on the increment that lands on the value
  // RULE_22 match on increment
  wire [ET_WIDTH-1:0] et_next = et_q + 1'b1;
  wire pd_match = et_inc && (et_next == ET_WIDTH'(pd_value_q));
  wire wu_match = et_inc && (et_next == ET_WIDTH'(wu_value_q));
  wire ovf_event = et_inc && (et_next == {ET_WIDTH{1'b1}});
  wire cd_event = countdown_active_flag && cd_tick && (cd_q == CD_WIDTH'(1));

  // gated alarm triggers
  // RULE_03 count-down alarm gate
  wire cd_trig = cd_event && countdown_alarm_enable;
  // RULE_04 overflow alarm gate
  wire ovf_trig = ovf_event && overflow_alarm_enable;
  // RULE_05 power-down alarm gate
  wire pd_trig = pd_match && powerdown_alarm_enable;
  // RULE_06 wake-up alarm gate
  wire wu_trig = wu_match && wakeup_alarm_enable;

  // persisting conditions block clears while the matching enable is set
  // RULE_07 clear refused while persisting
  wire [3:0] persist = {cd_at_zero && cd_enable, et_at_max && et_enable,
                        (et_q == ET_WIDTH'(pd_value_q)) && et_enable,
                        (et_q == ET_WIDTH'(wu_value_q)) && et_enable};
  wire [3:0] en_vec = {countdown_alarm_enable, overflow_alarm_enable, powerdown_alarm_enable, wakeup_alarm_enable};
  wire [3:0] set_vec = {cd_trig, ovf_trig, pd_trig, wu_trig};
  wire [3:0] clr_ok = record_clear & ~(en_vec & persist);
  // set wins over clear
  assign record_d = set_vec | (record_q & ~clr_ok);

  // action legality against the present power state
  // RULE_09 exit only from named state
  wire exit_deep = (cd_trig && cd_action == eoac_pkg::EOAC_ACT_DEEP) ||
                   (wu_trig && wu_action == eoac_pkg::EOAC_ACT_DEEP);
  wire exit_stby = (cd_trig && cd_action == eoac_pkg::EOAC_ACT_STBY) ||
                   (wu_trig && wu_action == eoac_pkg::EOAC_ACT_STBY);
  wire exit_tonly = (cd_trig && cd_action == eoac_pkg::EOAC_ACT_TONLY) ||
                    (wu_trig && wu_action == eoac_pkg::EOAC_ACT_TONLY);
  // RULE_08 count-down field decode
  // RULE_12 wake-up field decode
  wire do_exit_deep = exit_deep && power_state == eoac_pkg::EOAC_PS_DEEP;
  wire do_exit_stby = exit_stby && power_state == eoac_pkg::EOAC_PS_STBY;
  wire do_exit_tonly = exit_tonly && power_state == eoac_pkg::EOAC_PS_TONLY;
  // RULE_10 power-down field decode
  // RULE_11 entry only from active
  wire pd_ok = pd_trig && power_state == eoac_pkg::EOAC_PS_ACTIVE;
  wire do_enter_deep = pd_ok && pd_action == eoac_pkg::EOAC_ACT_DEEP;
  wire do_enter_stby = pd_ok && pd_action == eoac_pkg::EOAC_ACT_STBY;
  wire do_enter_tonly = pd_ok && pd_action == eoac_pkg::EOAC_ACT_TONLY;
  wire any_action = do_exit_deep || do_exit_stby || do_exit_tonly ||
                    do_enter_deep || do_enter_stby || do_enter_tonly;

  // transition request pulse for the power-state machine
  // RULE_14 rails restart on timer-only exit
  always_comb begin
    trans_d.enter_deep = do_enter_deep;
    trans_d.enter_stby = do_enter_stby;
    trans_d.enter_tonly = do_enter_tonly;
    trans_d.exit_to_active = do_exit_deep || do_exit_stby || do_exit_tonly;
    trans_d.restart_rails = do_exit_tonly;
  end

  // override falls only when software zeroes every action field
  // RULE_13 override until field zero
  wire action_wr_zero = wr_action && (reg_req.wdata[5:0] == 6'h00);
  wire override_d = any_action || (override_q && !action_wr_zero);

  // read mux; reserved bits read zero, status bits come from live state
  // RULE_01 count-down status bit
  // RULE_02 elapsed status bit
  wire [7:0] enable_rd = {countdown_active_flag, 2'b00, enable_q[`EOAC_BIT_CD_EN], et_running,
                          enable_q[2:0]};
  always_comb begin
    case (reg_req.addr)
      `EOAC_ADDR_ENABLE: rdata_d = enable_rd;
      `EOAC_ADDR_ACTION: rdata_d = {2'b00, action_q};
      `EOAC_ADDR_PD_LOW: rdata_d = pd_value_q[7:0];
      `EOAC_ADDR_PD_HIGH: rdata_d = pd_value_q[15:8];
      `EOAC_ADDR_WU_LOW: rdata_d = wu_value_q[7:0];
      `EOAC_ADDR_WU_MID: rdata_d = wu_value_q[15:8];
      `EOAC_ADDR_WU_HIGH: rdata_d = wu_value_q[23:16];
      default: rdata_d = `EOAC_RESET_BYTE;
    endcase
  end

  // control registers; only the writable enable bits are stored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_q <= `EOAC_RESET_BYTE;
      action_q <= 6'h00;
    end else begin
      if (wr_enable) begin
        enable_q <= reg_req.wdata & 8'h17;
      end
      if (wr_action) begin
        action_q <= reg_req.wdata[5:0];
      end
    end
  end

  // alarm values: low bytes wait in buffers until the top byte lands
  // RULE_15 power-down value load
  // RULE_17 wake-up value load
  // RULE_18 wake-up byte buffering
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pd_low_buf_q <= `EOAC_RESET_BYTE;
      pd_value_q <= 16'h0000;
      wu_low_buf_q <= `EOAC_RESET_BYTE;
      wu_mid_buf_q <= `EOAC_RESET_BYTE;
      wu_value_q <= 24'h000000;
    end else begin
      if (wr_pd_low) begin
        pd_low_buf_q <= reg_req.wdata;
      end
      if (wr_pd_high) begin
        pd_value_q <= {reg_req.wdata, pd_low_buf_q};
      end
      if (wr_wu_low) begin
        wu_low_buf_q <= reg_req.wdata;
      end
      if (wr_wu_mid) begin
        wu_mid_buf_q <= reg_req.wdata;
      end
      if (wr_wu_high) begin
        wu_value_q <= {reg_req.wdata, wu_mid_buf_q, wu_low_buf_q};
      end
    end
  end

  // status and output flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      record_q <= 4'h0;
      override_q <= 1'b0;
      trans_q <= '0;
      rdata_q <= `EOAC_RESET_BYTE;
    end else begin
      record_q <= record_d;
      override_q <= override_d;
      trans_q <= trans_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign alarm_record = record_q;
  assign pin_control_override = override_q;
  assign trans_req = trans_q;
  assign et_count = et_q;
  assign cd_count = cd_q;

  // a disabled alarm never sets its record
  gated_record_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_05
    (pd_match && !powerdown_alarm_enable && !record_q[1]) |=> !record_q[1])
    else $error("power-down record set while disabled");

  cd_gate_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_03
    cd_trig |=> record_q[3])
    else $error("count-down record missed");

  ovf_gate_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_04
    (ovf_event && !overflow_alarm_enable && !record_q[2]) |=> !record_q[2])
    else $error("overflow record set while disabled");

  wu_gate_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_06
    wu_trig |=> record_q[0])
    else $error("wake-up record missed");

  persist_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_07
    (record_q[2] && overflow_alarm_enable && et_at_max && et_enable) |=> record_q[2])
    else $error("overflow record cleared while persisting");

  pd_entry_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_11
    (trans_q.enter_deep || trans_q.enter_stby || trans_q.enter_tonly) |->
    $past(power_state) == eoac_pkg::EOAC_PS_ACTIVE)
    else $error("entry requested outside active");

  exit_state_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_09
    trans_q.restart_rails |-> $past(power_state) == eoac_pkg::EOAC_PS_TONLY)
    else $error("timer-only exit from wrong state");

  override_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_13
    (override_q && !wr_action) |=> override_q)
    else $error("override dropped without action write");

  wu_buffer_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_18
    (wr_wu_low && !wr_wu_high) |=> $stable(wu_value_q))
    else $error("wake-up value changed on low byte write");

  pd_load_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_15
    wr_pd_high |=> pd_value_q == {$past(reg_req.wdata), $past(pd_low_buf_q)})
    else $error("power-down value load wrong");

  et_sat_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_20
    (et_at_max && et_enable && !et_reset) |=> et_at_max)
    else $error("elapsed timer left its maximum");

  cd_stop_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_21
    (cd_at_zero && cd_enable && !cd_set) |=> cd_at_zero)
    else $error("count-down left zero");

  status_bit_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_01
    (reg_req.addr == `EOAC_ADDR_ENABLE) |=> reg_rdata[7] == $past(countdown_active_flag))
    else $error("count-down status readback wrong");

  et_status_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_02
    (reg_req.addr == `EOAC_ADDR_ENABLE) |=> reg_rdata[3] == $past(et_running))
    else $error("elapsed status readback wrong");

  // all three bytes land together, so a half-loaded value is never compared
  wu_load_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_17
    wr_wu_high |=> wu_value_q == {$past(reg_req.wdata), $past(wu_mid_buf_q),
                                  $past(wu_low_buf_q)})
    else $error("wake-up value load wrong");

endmodule // eoac_alarm_ctrl

// file: design/eoac_pkg.sv
// types shared by the alarm control block
package eoac_pkg;
  typedef enum logic [1:0] {
    EOAC_ACT_NONE = 2'b00,
    EOAC_ACT_DEEP = 2'b01,
    EOAC_ACT_STBY = 2'b10,
    EOAC_ACT_TONLY = 2'b11
  } eoac_action_type;
  typedef enum logic [1:0] {
    EOAC_PS_ACTIVE = 2'b00,
    EOAC_PS_DEEP = 2'b01,
    EOAC_PS_STBY = 2'b10,
    EOAC_PS_TONLY = 2'b11
  } eoac_pstate_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eoac_reg_req_type;
  typedef struct packed {
    logic enter_deep;
    logic enter_stby;
    logic enter_tonly;
    logic exit_to_active;
    logic restart_rails;
  } eoac_trans_type;
endpackage

// file: design/eoac_regs.svh
// register offsets, field positions and reset values of the alarm control block
`ifndef EOAC_REGS_SVH
`define EOAC_REGS_SVH
`define EOAC_ADDR_ENABLE 8'h61
`define EOAC_ADDR_ACTION 8'h62
`define EOAC_ADDR_PD_LOW 8'h63
`define EOAC_ADDR_PD_HIGH 8'h64
`define EOAC_ADDR_WU_LOW 8'h65
`define EOAC_ADDR_WU_MID 8'h66
`define EOAC_ADDR_WU_HIGH 8'h67
`define EOAC_BIT_CD_ACTIVE 7
`define EOAC_BIT_CD_EN 4
`define EOAC_BIT_ET_ACTIVE 3
`define EOAC_BIT_OVF_EN 2
`define EOAC_BIT_PD_EN 1
`define EOAC_BIT_WU_EN 0
`define EOAC_RESET_BYTE 8'h00
`define EOAC_CD_SET_VALUE 6'h3f
`define EOAC_ET_MAX 24'hffffff
`endif

// file: sim/eoac_alarm_ctrl_tb.sv
// self-checking bench for the engine-off timer alarm control block
`timescale 1ns/1ps

module eoac_alarm_ctrl_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  eoac_pkg::eoac_reg_req_type reg_req = '0;
  logic [7:0] reg_rdata;
  logic et_enable = 1'b0, et_stop = 1'b0, et_tick = 1'b0, et_reset = 1'b0;
  logic cd_enable = 1'b0, cd_stop = 1'b0, cd_tick = 1'b0, cd_set = 1'b0;
  logic [3:0] record_clear = 4'h0;
  eoac_pkg::eoac_pstate_type power_state = eoac_pkg::EOAC_PS_ACTIVE;
  logic [3:0] alarm_record;
  logic pin_control_override;
  eoac_pkg::eoac_trans_type trans_req;
  logic [23:0] et_count;
  logic [5:0] cd_count;
  logic [3:0] alarm_record_s;
  logic [3:0] et_count_s;
  logic [31:0] rng = 32'h0000a022;
  logic [4:0] tr_acc = 5'h00;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;

  // 125 MHz clock
  always #4 clk = ~clk;

  eoac_alarm_ctrl dut (
    .clk(clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .et_enable(et_enable), .et_stop(et_stop), .et_tick(et_tick), .et_reset(et_reset),
    .cd_enable(cd_enable), .cd_stop(cd_stop), .cd_tick(cd_tick), .cd_set(cd_set),
    .record_clear(record_clear), .power_state(power_state), .alarm_record(alarm_record),
    .pin_control_override(pin_control_override), .trans_req(trans_req),
    .et_count(et_count), .cd_count(cd_count)
  );

  // narrow elapsed timer copy: overflow and saturation are out of reach at full width
  eoac_alarm_ctrl #(.ET_WIDTH(4), .CD_WIDTH(6)) dut_ovf (
    .clk(clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(),
    .et_enable(et_enable), .et_stop(et_stop), .et_tick(et_tick), .et_reset(et_reset),
    .cd_enable(cd_enable), .cd_stop(cd_stop), .cd_tick(cd_tick), .cd_set(cd_set),
    .record_clear(record_clear), .power_state(power_state), .alarm_record(alarm_record_s),
    .pin_control_override(), .trans_req(),
    .et_count(et_count_s), .cd_count()
  );

  // xorshift step, fixed seed keeps runs repeatable
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // expected transition pulses {deep, stby, tonly, exit, rails} for alarm kind k
  function automatic logic [4:0] exp_tr(input int k, input logic [1:0] c, input logic [1:0] s,
                                        input logic en);
    if (!en || c == 2'h0) return 5'h00;
    if (k == 1) return (s != 2'h0) ? 5'h00 : 5'(5'h10 >> (c - 2'h1));
    if (s != c) return 5'h00;
    return (c == 2'h3) ? 5'h03 : 5'h02;
  endfunction

  task automatic summarize();
    if (err_total == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // registered outputs are read at the edge, before that edge's updates land
  task automatic cyc();
    @(posedge clk);
    tr_acc = tr_acc | trans_req;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask

  // write strobe is dropped for a cycle so no signal is driven twice per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    cyc();
    reg_req.wr <= 1'b0;
    cyc();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_req.addr <= a;
    cyc();
    cyc();
    chk("reg_rdata", 32'(e), 32'(reg_rdata));
  endtask

  // one alarm pass: kind 0 wake-up, 1 power-down, 3 count-down
  task automatic alarm(input int k, input logic [1:0] c, input logic [1:0] st, input logic en);
    logic [15:0] v;
    logic [4:0] e;
    v = 16'h0002 + {12'h000, rng[3:0]};
    rng = xs(rng);
    e = exp_tr(k, c, st, en);
    // stale records only clear once the enable is down
    wr(8'h61, 8'h00);
    record_clear <= 4'hf;
    cd_enable <= 1'b0;
    et_reset <= 1'b1;
    cyc();
    record_clear <= 4'h0;
    cd_enable <= 1'b1;
    et_reset <= 1'b0;
    if (k == 1) begin
      wr(8'h63, v[7:0]);
      wr(8'h64, v[15:8]);
    end
    if (k == 0) begin
      wr(8'h65, v[7:0]);
      wr(8'h66, v[15:8]);
      wr(8'h67, 8'h00);
    end
    wr(8'h61, en ? ((k == 3) ? 8'h10 : (k == 1) ? 8'h02 : 8'h01) : 8'h00);
    wr(8'h62, 8'({6'h00, c} << ((k == 3) ? 4 : k * 2)));
    power_state <= eoac_pkg::eoac_pstate_type'(st);
    tr_acc = 5'h00;
    if (k == 3) begin
      cd_tick <= 1'b1;
      repeat (63) cyc();
      cd_tick <= 1'b0;
    end else begin
      et_tick <= 1'b1;
      repeat (int'(v)) cyc();
      et_tick <= 1'b0;
    end
    repeat (3) cyc();
    chk("alarm_record", 32'(en), 32'(alarm_record[k]));
    chk("trans_req", 32'(e), 32'(tr_acc));
    if (k == 3) chk("cd_count", 32'h0, 32'(cd_count));
    else chk("et_count", 32'(v), 32'(et_count));
    if (en) begin
      record_clear <= 4'hf;
      cyc();
      record_clear <= 4'h0;
      cyc();
      cyc();
      chk("record_kept", 32'h1, 32'(alarm_record[k]));
    end
    chk("override", 32'(e != 5'h00), 32'(pin_control_override));
    wr(8'h62, 8'h00);
    cyc();
    chk("override", 32'h0, 32'(pin_control_override));
  endtask

  // hang guard, well above the roughly 1200 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    logic [23:0] a;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    cyc();
    chk("cd_count", 32'h3f, 32'(cd_count));
    for (int i = 'h61; i <= 'h67; i++) rd(8'(i), 8'h00);
    rd(8'h70, 8'h00);
    // status bits and reserved bits must ignore writes
    wr(8'h70, 8'hff);
    wr(8'h61, 8'hff);
    rd(8'h61, 8'h17);
    wr(8'h62, 8'hff);
    rd(8'h62, 8'h3f);
    wr(8'h61, 8'h00);
    wr(8'h62, 8'h00);
    et_enable <= 1'b1;
    cd_enable <= 1'b1;
    cd_set <= 1'b1;
    cyc();
    cd_set <= 1'b0;
    rd(8'h61, 8'h88);
    et_stop <= 1'b1;
    cd_stop <= 1'b1;
    rd(8'h61, 8'h00);
    et_stop <= 1'b0;
    cd_stop <= 1'b0;
    // alarm values read back the active copy, not the pending bytes
    a = rng[23:0];
    rng = xs(rng);
    wr(8'h63, a[7:0]);
    rd(8'h63, 8'h00);
    wr(8'h64, a[15:8]);
    rd(8'h63, a[7:0]);
    rd(8'h64, a[15:8]);
    wr(8'h65, a[7:0]);
    wr(8'h66, a[15:8]);
    rd(8'h65, 8'h00);
    rd(8'h66, 8'h00);
    wr(8'h67, a[23:16]);
    rd(8'h65, a[7:0]);
    rd(8'h66, a[15:8]);
    rd(8'h67, a[23:16]);
    // overflow alarm on the narrow copy: count tops out at 4'hf and stays there
    wr(8'h61, 8'h04);
    et_reset <= 1'b1;
    cyc();
    et_reset <= 1'b0;
    et_tick <= 1'b1;
    repeat (17) cyc();
    et_tick <= 1'b0;
    cyc();
    chk("ovf_record", 32'h1, 32'(alarm_record_s[2]));
    chk("et_count_s", 32'hf, 32'(et_count_s));
    chk("ovf_record_wide", 32'h0, 32'(alarm_record[2]));
    // clear is refused while enabled at the top, accepted once the enable drops
    record_clear <= 4'h4;
    cyc();
    record_clear <= 4'h0;
    cyc();
    chk("ovf_kept", 32'h1, 32'(alarm_record_s[2]));
    wr(8'h61, 8'h00);
    record_clear <= 4'h4;
    cyc();
    record_clear <= 4'h0;
    cyc();
    chk("ovf_cleared", 32'h0, 32'(alarm_record_s[2]));
    // every action code, once in its own state (active for power-down) and once in a random one
    for (int k = 0; k < 4; k++) begin
      if (k != 2) begin
        for (int c = 0; c < 4; c++) begin
          alarm(k, 2'(c), (k == 1) ? 2'h0 : 2'(c), 1'b1);
          alarm(k, 2'(c), rng[6:5], rng[4]);
          rng = xs(rng);
        end
      end
    end
    summarize();
  end
endmodule // eoac_alarm_ctrl_tb
